// >>> src/cis_defines.vh
// register map, field positions, opcodes and timing counts for the instruction core
`ifndef CIS_DEFINES_VH
`define CIS_DEFINES_VH

// register byte offsets
`define CIS_REG_CMD 8'h00
`define CIS_REG_STATUS 8'h04
`define CIS_REG_ACC 8'h08
`define CIS_REG_PC 8'h0c
`define CIS_REG_STACK 8'h10
`define CIS_REG_WDT 8'h14
`define CIS_REG_DMEM 8'h40

// command word fields
`define CIS_CMD_OP_HI 4
`define CIS_CMD_OP_LO 0
`define CIS_CMD_IMM_HI 15
`define CIS_CMD_IMM_LO 8
`define CIS_CMD_ADR_HI 19
`define CIS_CMD_ADR_LO 16
`define CIS_CMD_TGT_HI 31
`define CIS_CMD_TGT_LO 20

// status bit positions
`define CIS_ST_C 0
`define CIS_ST_AC 1
`define CIS_ST_Z 2
`define CIS_ST_OV 3
`define CIS_ST_SC 4
`define CIS_ST_CZ 5
`define CIS_ST_HALT 6
`define CIS_ST_WDTX 7
`define CIS_ST_IRQEN 8
`define CIS_ST_BUSY 9

// opcodes
`define CIS_OP_NOP 5'h00
`define CIS_OP_SLEEP 5'h01
`define CIS_OP_INC 5'h02
`define CIS_OP_INCA 5'h03
`define CIS_OP_GOTO 5'h04
`define CIS_OP_MOV_AM 5'h05
`define CIS_OP_MOV_AX 5'h06
`define CIS_OP_MOV_MA 5'h07
`define CIS_OP_OR_AM 5'h08
`define CIS_OP_OR_AX 5'h09
`define CIS_OP_ORM 5'h0a
`define CIS_OP_RET 5'h0b
`define CIS_OP_RET_AX 5'h0c
`define CIS_OP_IRET 5'h0d
`define CIS_OP_RL 5'h0e
`define CIS_OP_RLA 5'h0f
`define CIS_OP_RLC 5'h10
`define CIS_OP_RLCA 5'h11
`define CIS_OP_RR 5'h12
`define CIS_OP_RRA 5'h13
`define CIS_OP_RRC 5'h14
`define CIS_OP_RRCA 5'h15
`define CIS_OP_SBC_AM 5'h16
`define CIS_OP_SBC_AX 5'h17
`define CIS_OP_SBCM 5'h18
`define CIS_OP_DSKIP 5'h19
`define CIS_OP_DSKIPA 5'h1a
`define CIS_OP_SET 5'h1b

// reset values and timing
`define CIS_RST_PC 12'h000
`define CIS_RST_ACC 8'h00
`define CIS_IRQ_VECTOR 12'h004
`define CIS_WDT_PRESCALE 8'hff
`define CIS_WDT_LIMIT 16'hffff

`endif

// >>> src/cis_alu.v
// datapath for the arithmetic, logic and rotate operations of the instruction core
`include "cis_defines.vh"

module cis_alu (
  // operation and operands
  input wire [4:0] op,
  input wire [7:0] acc,
  input wire [7:0] mem,
  input wire [7:0] imm,
  input wire c_in,
  input wire cz_in,
  // result and flags
  output reg [7:0] res,
  output reg c_out,
  output reg ac_out,
  output reg z_out,
  output reg ov_out,
  output reg sc_out,
  output reg cz_out
);

  reg [8:0] diff;
  reg [4:0] ldiff;
  reg [7:0] sub_b;

  always @* begin
    sub_b = (op == `CIS_OP_SBC_AX) ? imm : mem;
    // borrow is the inverted carry
    diff = {1'b0, acc} - {1'b0, sub_b} - {8'h00, ~c_in};
    ldiff = {1'b0, acc[3:0]} - {1'b0, sub_b[3:0]} - {4'h0, ~c_in};
    res = mem;
    c_out = c_in;
    ac_out = ~ldiff[4];
    ov_out = (acc[7] != sub_b[7]) && (diff[7] != acc[7]);
    sc_out = ((acc[7] != sub_b[7]) && (diff[7] != acc[7])) ^ diff[7];
    case (op)
      `CIS_OP_INC, `CIS_OP_INCA: res = mem + 8'h01;
      `CIS_OP_MOV_AM: res = mem;
      `CIS_OP_MOV_AX, `CIS_OP_RET_AX: res = imm;
      `CIS_OP_MOV_MA: res = acc;
      `CIS_OP_OR_AM, `CIS_OP_ORM: res = acc | mem;
      `CIS_OP_OR_AX: res = acc | imm;
      `CIS_OP_RL, `CIS_OP_RLA: res = {mem[6:0], mem[7]};
      `CIS_OP_RLC, `CIS_OP_RLCA: begin
        res = {mem[6:0], c_in};
        c_out = mem[7];
      end
      `CIS_OP_RR, `CIS_OP_RRA: res = {mem[0], mem[7:1]};
      `CIS_OP_RRC, `CIS_OP_RRCA: begin
        res = {c_in, mem[7:1]};
        c_out = mem[0];
      end
      `CIS_OP_SBC_AM, `CIS_OP_SBC_AX, `CIS_OP_SBCM: begin
        res = diff[7:0];
        c_out = ~diff[8];
      end
      `CIS_OP_DSKIP, `CIS_OP_DSKIPA: res = mem - 8'h01;
      `CIS_OP_SET: res = 8'hff;
      default: res = mem;
    endcase
    z_out = (res == 8'h00);
    // multi-byte null keeps chained zero across bytes
    cz_out = (res == 8'h00) & cz_in;
  end

endmodule

// >>> src/cis_core.v
// instruction core for the halt-to-set group, with a classic wishbone register slave
// Function
// - sleep halts, clears watchdog, sets halted flag
// - add one to byte, memory or accumulator
// - goto loads pc, two cycles, no flags
// - moves into accumulator leave flags alone
// - accumulator to memory, flags untouched
// - no-op only advances the pc
// - or into accumulator updates zero only
// - or into memory updates zero only
// - return pops stack into pc
// - return loads pc and immediate accumulator
// - interrupt return restores pc, allows irqs
// - pending irq served before main program
// - left rotate, bit 7 into bit 0
// - left rotate through carry, carry only
// - right rotate, bit 0 into bit 7
// - right rotate through carry, carry only
// - subtract borrow, carry set when nonnegative
// - memory subtract writes byte, same flags
// - decrement memory, skip on zero, two cycles when skipping
// - memory decrement into accumulator, skip on zero value
// - set forces all byte bits high
`include "cis_defines.vh"

module cis_core #(
  parameter PC_W = 12,
  parameter DMEM_AW = 4,
  parameter STACK_AW = 3,
  parameter [15:0] WDT_LIMIT = `CIS_WDT_LIMIT
) (
  // clock and reset
  input wire ref_clk,
  input wire reset,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // pins
  input wire irq_request,
  input wire wake_request,
  output reg sys_clk_run
);

  localparam DMEM_N = 1 << DMEM_AW;
  localparam STACK_N = 1 << STACK_AW;
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_EXEC = 3'b010;
  localparam [2:0] ST_DUMMY = 3'b100;

  reg [7:0] dmem [0:DMEM_N-1];
  reg [PC_W-1:0] stack [0:STACK_N-1];
  reg [2:0] state_q;
  reg [31:0] cmd_q;
  reg [7:0] acc_q;
  reg [PC_W-1:0] pc_q;
  reg [STACK_AW:0] sp_q;
  reg c_q, ac_q, z_q, ov_q, sc_q, cz_q;
  reg halted_flag_q, watchdog_expired_flag_q, global_irq_allow_q;
  reg [7:0] prescale_q;
  reg [15:0] watchdog_counter_q;
  reg irq_s1_q, irq_s2_q, wake_s1_q, wake_s2_q;

  wire [4:0] op = cmd_q[`CIS_CMD_OP_HI:`CIS_CMD_OP_LO];
  wire [7:0] imm = cmd_q[`CIS_CMD_IMM_HI:`CIS_CMD_IMM_LO];
  wire [DMEM_AW-1:0] maddr = cmd_q[`CIS_CMD_ADR_LO+DMEM_AW-1:`CIS_CMD_ADR_LO];
  wire [PC_W-1:0] target = cmd_q[`CIS_CMD_TGT_LO+PC_W-1:`CIS_CMD_TGT_LO];
  wire [7:0] mval = dmem[maddr];
  wire [PC_W-1:0] stack_top = stack[sp_q[STACK_AW-1:0] - 1'b1];

  wire [7:0] alu_res;
  wire alu_c, alu_ac, alu_z, alu_ov, alu_sc, alu_cz;

  cis_alu u_alu (
    .op(op),
    .acc(acc_q),
    .mem(mval),
    .imm(imm),
    .c_in(c_q),
    .cz_in(cz_q),
    .res(alu_res),
    .c_out(alu_c),
    .ac_out(alu_ac),
    .z_out(alu_z),
    .ov_out(alu_ov),
    .sc_out(alu_sc),
    .cz_out(alu_cz)
  );

  // bus decode
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  wire is_dmem = (wb_adr_i[7:6] == 2'b01) && (wb_adr_i[5:2] < DMEM_N);
  wire [DMEM_AW-1:0] bus_dmem_idx = wb_adr_i[DMEM_AW+1:2];
  wire cmd_start = bus_wr && (wb_adr_i == `CIS_REG_CMD) && (state_q == ST_IDLE) && !halted_flag_q;

  // operation classes
  reg wr_mem, wr_acc, upd_z, upd_c, upd_arith, skip_cond, is_pop;
  always @* begin
    wr_mem = 1'b0;
    wr_acc = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    upd_arith = 1'b0;
    skip_cond = 1'b0;
    is_pop = 1'b0;
    case (op)
      `CIS_OP_INC, `CIS_OP_ORM: begin
        wr_mem = 1'b1;
        upd_z = 1'b1;
      end
      `CIS_OP_INCA, `CIS_OP_OR_AM, `CIS_OP_OR_AX: begin
        wr_acc = 1'b1;
        upd_z = 1'b1;
      end
      `CIS_OP_MOV_AM, `CIS_OP_MOV_AX: wr_acc = 1'b1;
      `CIS_OP_MOV_MA, `CIS_OP_RL, `CIS_OP_RR, `CIS_OP_SET: wr_mem = 1'b1;
      `CIS_OP_RLA, `CIS_OP_RRA: wr_acc = 1'b1;
      `CIS_OP_RLC, `CIS_OP_RRC: begin
        wr_mem = 1'b1;
        upd_c = 1'b1;
      end
      `CIS_OP_RLCA, `CIS_OP_RRCA: begin
        wr_acc = 1'b1;
        upd_c = 1'b1;
      end
      `CIS_OP_SBC_AM, `CIS_OP_SBC_AX: begin
        wr_acc = 1'b1;
        upd_arith = 1'b1;
      end
      `CIS_OP_SBCM: begin
        wr_mem = 1'b1;
        upd_arith = 1'b1;
      end
      `CIS_OP_DSKIP: begin
        wr_mem = 1'b1;
        skip_cond = alu_z;
      end
      `CIS_OP_DSKIPA: begin
        wr_acc = 1'b1;
        skip_cond = alu_z;
      end
      `CIS_OP_RET: is_pop = 1'b1;
      `CIS_OP_RET_AX: begin
        is_pop = 1'b1;
        wr_acc = 1'b1;
      end
      `CIS_OP_IRET: is_pop = 1'b1;
      default: is_pop = 1'b0;
    endcase
  end

  // pin synchronisers
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irq_s1_q <= 1'b0;
      irq_s2_q <= 1'b0;
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
    end else begin
      irq_s1_q <= irq_request;
      irq_s2_q <= irq_s1_q;
      wake_s1_q <= wake_request;
      wake_s2_q <= wake_s1_q;
    end
  end

  // sequencer, pc and stack
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
      cmd_q <= 32'h0000_0000;
      pc_q <= `CIS_RST_PC;
      sp_q <= {(STACK_AW+1){1'b0}};
      global_irq_allow_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (cmd_start) begin
            cmd_q <= wb_dat_i;
            state_q <= ST_EXEC;
          end else if (bus_wr && wb_adr_i == `CIS_REG_STACK && sp_q != STACK_N) begin
            stack[sp_q[STACK_AW-1:0]] <= wb_dat_i[PC_W-1:0];
            sp_q <= sp_q + 1'b1;
          end else if (bus_wr && wb_adr_i == `CIS_REG_PC) begin
            pc_q <= wb_dat_i[PC_W-1:0];
          end
          if (bus_wr && wb_adr_i == `CIS_REG_STATUS) begin
            global_irq_allow_q <= wb_dat_i[`CIS_ST_IRQEN];
          end
        end
        ST_EXEC: begin
          // goto and a taken skip spend a dummy cycle; all else ends here
          state_q <= (op == `CIS_OP_GOTO || skip_cond) ? ST_DUMMY : ST_IDLE;
          if (op == `CIS_OP_GOTO) begin
            pc_q <= target;
          end else if (is_pop && sp_q != 0) begin
            sp_q <= sp_q - 1'b1;
            pc_q <= stack_top;
            if (op == `CIS_OP_IRET) begin
              if (irq_s2_q) begin
                // pending request: restored pc goes back on the stack, vector taken now
                stack[sp_q[STACK_AW-1:0] - 1'b1] <= stack_top;
                sp_q <= sp_q;
                pc_q <= `CIS_IRQ_VECTOR;
                global_irq_allow_q <= 1'b0;
              end else begin
                global_irq_allow_q <= 1'b1;
              end
            end
          end else if (skip_cond) begin
            pc_q <= pc_q + 2'd2;
          end else if (op != `CIS_OP_SLEEP) begin
            pc_q <= pc_q + 1'b1;
          end
        end
        ST_DUMMY: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // accumulator and status flags
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      acc_q <= `CIS_RST_ACC;
      c_q <= 1'b0;
      ac_q <= 1'b0;
      z_q <= 1'b0;
      ov_q <= 1'b0;
      sc_q <= 1'b0;
      cz_q <= 1'b0;
    end else if (state_q == ST_EXEC) begin
      if (wr_acc) begin
        acc_q <= alu_res;
      end
      if (upd_z || upd_arith) begin
        z_q <= alu_z;
      end
      if (upd_c || upd_arith) begin
        c_q <= alu_c;
      end
      if (upd_arith) begin
        ac_q <= alu_ac;
        ov_q <= alu_ov;
        sc_q <= alu_sc;
        cz_q <= alu_cz;
      end
    end else if (state_q == ST_IDLE && bus_wr) begin
      if (wb_adr_i == `CIS_REG_ACC) begin
        acc_q <= wb_dat_i[7:0];
      end
      if (wb_adr_i == `CIS_REG_STATUS) begin
        c_q <= wb_dat_i[`CIS_ST_C];
        ac_q <= wb_dat_i[`CIS_ST_AC];
        z_q <= wb_dat_i[`CIS_ST_Z];
        ov_q <= wb_dat_i[`CIS_ST_OV];
        sc_q <= wb_dat_i[`CIS_ST_SC];
        cz_q <= wb_dat_i[`CIS_ST_CZ];
      end
    end
  end

  // data memory: execution wins over a bus write in the same cycle
  always @(posedge ref_clk) begin
    if (state_q == ST_EXEC && wr_mem) begin
      dmem[maddr] <= alu_res;
    end else if (bus_wr && is_dmem) begin
      dmem[bus_dmem_idx] <= wb_dat_i[7:0];
    end
  end

  // power-down and watchdog
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      halted_flag_q <= 1'b0;
      watchdog_expired_flag_q <= 1'b0;
      prescale_q <= 8'h00;
      watchdog_counter_q <= 16'h0000;
      sys_clk_run <= 1'b1;
    end else if (state_q == ST_EXEC && op == `CIS_OP_SLEEP) begin
      halted_flag_q <= 1'b1;
      // an expiry landing in the sleep cycle itself is kept: the set wins over the clear
      watchdog_expired_flag_q <= (prescale_q == `CIS_WDT_PRESCALE) && (watchdog_counter_q == WDT_LIMIT);
      prescale_q <= 8'h00;
      watchdog_counter_q <= 16'h0000;
      sys_clk_run <= 1'b0;
    end else if (halted_flag_q) begin
      // gated clock: nothing counts until a wake request
      if (wake_s2_q) begin
        sys_clk_run <= 1'b1;
        halted_flag_q <= 1'b0;
      end
    end else begin
      prescale_q <= prescale_q + 1'b1;
      if (prescale_q == `CIS_WDT_PRESCALE) begin
        if (watchdog_counter_q == WDT_LIMIT) begin
          watchdog_expired_flag_q <= 1'b1;
          watchdog_counter_q <= 16'h0000;
        end else begin
          watchdog_counter_q <= watchdog_counter_q + 1'b1;
        end
      end
    end
  end

  // bus answer, one cycle after the request
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h0000_0000;
      if (bus_req && !wb_we_i) begin
        if (is_dmem) begin
          wb_dat_o <= {24'h000000, dmem[bus_dmem_idx]};
        end else begin
          case (wb_adr_i)
            `CIS_REG_CMD: wb_dat_o <= cmd_q;
            `CIS_REG_STATUS: wb_dat_o <= {22'h0, (state_q != ST_IDLE), global_irq_allow_q,
              watchdog_expired_flag_q, halted_flag_q, cz_q, sc_q, ov_q, z_q, ac_q, c_q};
            `CIS_REG_ACC: wb_dat_o <= {24'h000000, acc_q};
            `CIS_REG_PC: wb_dat_o <= {{(32-PC_W){1'b0}}, pc_q};
            `CIS_REG_STACK: wb_dat_o <= {{(31-STACK_AW){1'b0}}, sp_q};
            `CIS_REG_WDT: wb_dat_o <= {16'h0000, watchdog_counter_q};
            default: wb_dat_o <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

endmodule

// >>> test/cis_core_chk.sv
// port-level assertions for the instruction core
`include "cis_defines.vh"
module cis_core_chk (
  // clock and reset
  input wire ref_clk,
  input wire reset,
  // bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // pins
  input wire wake_request,
  input wire sys_clk_run
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // only a command write of the halt opcode with byte lane 0 selected counts
  wire halt_wr = take & wb_we_i & wb_sel_i[0] & (wb_adr_i == `CIS_REG_CMD) & (wb_dat_i[4:0] == `CIS_OP_SLEEP);
  ack_follows_a: assert property (take |=> wb_ack_o) else $error("ack missing");
  ack_cause_a: assert property (wb_ack_o |-> $past(take)) else $error("ack without request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  wr_data_zero_a: assert property (wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0) else $error("write data");
  halt_stop_a: assert property (halt_wr && sys_clk_run && !wake_request |-> ##[1:4] !sys_clk_run)
    else $error("clock not stopped");
  halt_hold_a: assert property (!wake_request [*4] ##0 !sys_clk_run |=> !sys_clk_run)
    else $error("clock restarted alone");
  wake_run_a: assert property ($rose(wake_request) && !sys_clk_run |-> ##[1:6] sys_clk_run)
    else $error("no wake");
  reset_state_a: assert property ($fell(reset) |-> sys_clk_run && !wb_ack_o && wb_dat_o == 32'h0)
    else $error("bad reset state");
  cover property (halt_wr);
  cover property ($rose(sys_clk_run));
  cover property (take && !wb_we_i);
endmodule

bind cis_core cis_core_chk i_cis_core_chk (.ref_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wake_request, .sys_clk_run);

// >>> test/tb.sv
// self-checking bench for the instruction core
`include "cis_defines.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic irq_request = 1'b0;
  logic wake_request = 1'b0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o;
  wire sys_clk_run;
  logic [31:0] rd;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  always #4 ref_clk = ~ref_clk;
  // short watchdog limit so expiry shows within the run
  cis_core #(.WDT_LIMIT(16'h0003)) i_cis_core (.ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_request(irq_request), .wake_request(wake_request),
    .sys_clk_run(sys_clk_run));
  task automatic results;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      mismatches++;
      results;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  // halted and expired bits move on their own, so only flags and irq allow
  task automatic st(input logic [31:0] e);
    wb(1'b0, `CIS_REG_STATUS, 32'h0);
    check(rd & 32'h13f, e);
  endtask
  function automatic logic [7:0] ma(input logic [3:0] m);
    return `CIS_REG_DMEM + {2'b00, m, 2'b00};
  endfunction
  task automatic ex(input logic [4:0] op, input logic [7:0] x, input logic [3:0] m, input logic [11:0] t);
    wr(`CIS_REG_CMD, {t, m, x, 3'b000, op});
    do wb(1'b0, `CIS_REG_STATUS, 32'h0); while (rd[`CIS_ST_BUSY] !== 1'b0);
  endtask
  task automatic t_move;
    wr(`CIS_REG_STATUS, 32'h3f);
    ex(`CIS_OP_MOV_AX, 8'h5a, 4'h0, 12'h0);
    rc(`CIS_REG_ACC, 32'h5a);
    ex(`CIS_OP_MOV_MA, 8'h00, 4'h3, 12'h0);
    rc(ma(4'h3), 32'h5a);
    wr(ma(4'h4), 32'hc3);
    ex(`CIS_OP_MOV_AM, 8'h00, 4'h4, 12'h0);
    rc(`CIS_REG_ACC, 32'hc3);
    wr(`CIS_REG_PC, 32'h20);
    ex(`CIS_OP_NOP, 8'h00, 4'h0, 12'h0);
    rc(`CIS_REG_PC, 32'h21);
    st(32'h3f);
    rc(8'h20, 32'h0);
    $display("test move done");
  endtask
  task automatic t_logic;
    wr(`CIS_REG_STATUS, 32'h39);
    wr(ma(4'h1), 32'hff);
    ex(`CIS_OP_INC, 8'h00, 4'h1, 12'h0);
    rc(ma(4'h1), 32'h0);
    st(32'h3d);
    wr(ma(4'h2), 32'h7f);
    ex(`CIS_OP_INCA, 8'h00, 4'h2, 12'h0);
    rc(`CIS_REG_ACC, 32'h80);
    rc(ma(4'h2), 32'h7f);
    st(32'h39);
    wr(`CIS_REG_ACC, 32'h0);
    ex(`CIS_OP_OR_AX, 8'h00, 4'h0, 12'h0);
    st(32'h3d);
    ex(`CIS_OP_OR_AX, 8'h21, 4'h0, 12'h0);
    st(32'h39);
    wr(ma(4'h5), 32'h10);
    ex(`CIS_OP_OR_AM, 8'h00, 4'h5, 12'h0);
    rc(`CIS_REG_ACC, 32'h31);
    wr(`CIS_REG_ACC, 32'h42);
    ex(`CIS_OP_ORM, 8'h00, 4'h5, 12'h0);
    rc(ma(4'h5), 32'h52);
    rc(`CIS_REG_ACC, 32'h42);
    st(32'h39);
    $display("test logic done");
  endtask
  task automatic t_rot;
    logic [7:0] v;
    logic [7:0] r;
    logic c;
    logic nc;
    v = 8'h96;
    for (int k = 0; k < 8; k++) begin
      c = k[2];
      r = k[2] ? {v[0], v[7:1]} : {v[6:0], v[7]};
      nc = c;
      if (k[1]) begin
        r = k[2] ? {c, v[7:1]} : {v[6:0], c};
        nc = k[2] ? v[0] : v[7];
      end
      wr(`CIS_REG_STATUS, {26'h0, 5'h1f, c});
      wr(`CIS_REG_ACC, 32'h55);
      wr(ma(4'h6), {24'h0, v});
      ex(`CIS_OP_RL + 5'(k), 8'h00, 4'h6, 12'h0);
      rc(ma(4'h6), k[0] ? v : r);
      rc(`CIS_REG_ACC, k[0] ? r : 8'h55);
      st({26'h0, 5'h1f, nc});
    end
    $display("test rotate done");
  endtask
  task automatic sb(input logic [4:0] op, input logic [7:0] s, a, m, x, y, f);
    wr(`CIS_REG_STATUS, {24'h0, s});
    wr(`CIS_REG_ACC, {24'h0, a});
    wr(ma(4'h7), {24'h0, m});
    ex(op, x, 4'h7, 12'h0);
    rc(op == `CIS_OP_SBCM ? ma(4'h7) : `CIS_REG_ACC, {24'h0, y});
    st({24'h0, f});
  endtask
  task automatic t_sub;
    sb(`CIS_OP_SBC_AX, 8'h01, 8'h80, 8'h00, 8'h01, 8'h7f, 8'h19);
    sb(`CIS_OP_SBCM, 8'h21, 8'h05, 8'h05, 8'h00, 8'h00, 8'h27);
    sb(`CIS_OP_SBC_AM, 8'h00, 8'h10, 8'h10, 8'h00, 8'hff, 8'h10);
    $display("test subtract done");
  endtask
  task automatic t_flow;
    wr(`CIS_REG_STATUS, 32'h3f);
    ex(`CIS_OP_GOTO, 8'h00, 4'h0, 12'h123);
    rc(`CIS_REG_PC, 32'h123);
    wr(`CIS_REG_STACK, 32'h045);
    ex(`CIS_OP_RET, 8'h00, 4'h0, 12'h0);
    rc(`CIS_REG_PC, 32'h045);
    rc(`CIS_REG_STACK, 32'h0);
    wr(`CIS_REG_STACK, 32'h067);
    ex(`CIS_OP_RET_AX, 8'h3c, 4'h0, 12'h0);
    rc(`CIS_REG_PC, 32'h067);
    rc(`CIS_REG_ACC, 32'h3c);
    st(32'h3f);
    wr(`CIS_REG_STACK, 32'h089);
    ex(`CIS_OP_IRET, 8'h00, 4'h0, 12'h0);
    rc(`CIS_REG_PC, 32'h089);
    st(32'h13f);
    wr(`CIS_REG_STATUS, 32'h3f);
    irq_request <= 1'b1;
    wr(`CIS_REG_STACK, 32'h0aa);
    ex(`CIS_OP_IRET, 8'h00, 4'h0, 12'h0);
    rc(`CIS_REG_PC, {20'h0, `CIS_IRQ_VECTOR});
    rc(`CIS_REG_STACK, 32'h1);
    irq_request <= 1'b0;
    $display("test flow done");
  endtask
  task automatic t_skip;
    wr(`CIS_REG_STATUS, 32'h3f);
    wr(`CIS_REG_PC, 32'h10);
    wr(ma(4'h8), 32'h1);
    ex(`CIS_OP_DSKIP, 8'h00, 4'h8, 12'h0);
    rc(ma(4'h8), 32'h0);
    rc(`CIS_REG_PC, 32'h12);
    ex(`CIS_OP_DSKIP, 8'h00, 4'h8, 12'h0);
    rc(ma(4'h8), 32'hff);
    rc(`CIS_REG_PC, 32'h13);
    wr(ma(4'h9), 32'h1);
    ex(`CIS_OP_DSKIPA, 8'h00, 4'h9, 12'h0);
    rc(`CIS_REG_ACC, 32'h0);
    rc(ma(4'h9), 32'h1);
    rc(`CIS_REG_PC, 32'h15);
    ex(`CIS_OP_SET, 8'h00, 4'h9, 12'h0);
    rc(ma(4'h9), 32'hff);
    st(32'h3f);
    $display("test skip done");
  endtask
  task automatic t_sleep;
    wr(`CIS_REG_PC, 32'h30);
    wr(ma(4'ha), 32'h77);
    // watchdog at limit 3 expires about 1024 cycles after reset
    repeat (1100) @(posedge ref_clk);
    wb(1'b0, `CIS_REG_STATUS, 32'h0);
    check(rd[`CIS_ST_WDTX], 1'b1);
    ex(`CIS_OP_SLEEP, 8'h00, 4'h0, 12'h0);
    wb(1'b0, `CIS_REG_STATUS, 32'h0);
    check(rd[7:6], 2'b01);
    rc(`CIS_REG_WDT, 32'h0);
    check(sys_clk_run, 1'b0);
    ex(`CIS_OP_NOP, 8'h00, 4'h0, 12'h0);
    rc(`CIS_REG_PC, 32'h30);
    rc(ma(4'ha), 32'h77);
    wake_request <= 1'b1;
    for (int n = 0; n < 20 && sys_clk_run !== 1'b1; n++) @(posedge ref_clk);
    check(sys_clk_run, 1'b1);
    wake_request <= 1'b0;
    wb(1'b0, `CIS_REG_STATUS, 32'h0);
    check(rd[`CIS_ST_HALT], 1'b0);
    $display("test sleep done");
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    t_move;
    t_logic;
    t_rot;
    t_sub;
    t_flow;
    t_skip;
    t_sleep;
    results;
  end
endmodule
